// >>> epc_pin_ctrl.sv
// External bus pin state controller: drive state of bus and port pins per mode and power state
`default_nettype none

module epc_pin_ctrl
(
    input  wire logic        i_core_clk,
    input  wire logic        i_rst,
    input  wire logic        i_ce,
    input  wire logic        i_res_n,
    input  wire logic [2:0]  i_mode,
    input  wire logic        i_hw_standby,
    input  wire logic        i_sw_standby,
    input  wire logic        i_bus_release_req,
    input  wire logic        i_standby_output_hold,
    input  wire logic        i_addr_bit23_port_sel,
    input  wire logic        i_addr_bit22_port_sel,
    input  wire logic        i_addr_bit21_port_sel,
    input  wire logic        i_addr_bit20_port_sel,
    input  wire logic        i_chip_select7_enable,
    input  wire logic        i_chip_select6_enable,
    input  wire logic        i_chip_select5_enable,
    input  wire logic        i_chip_select4_enable,
    input  wire logic [3:0]  i_cs_ddr,
    input  wire logic        i_clock_out_stop,
    input  wire logic        i_watchdog_overflow_reset,
    input  wire logic [23:0] i_addr,
    input  wire logic [3:0]  i_strobe,
    input  wire logic [7:0]  i_cs,
    input  wire logic        i_data_drive,
    output logic             o_port_input_force,
    output logic             o_bus_released,
    output logic [19:0]      o_addr_out,
    output logic             o_addr_oe,
    output logic [3:0]       o_upper_addr_out,
    output logic [3:0]       o_upper_addr_oe,
    output logic [3:0]       o_upper_port_mode,
    output logic             o_data_oe,
    output logic [3:0]       o_strobe_out,
    output logic             o_strobe_oe,
    output logic [3:0]       o_cs_out,
    output logic [3:0]       o_cs_oe,
    output logic [3:0]       o_cs_hi_out,
    output logic [3:0]       o_cs_hi_oe,
    output logic             o_clk_pin_oe,
    output logic             o_watchdog_reset_out,
    output logic             o_watchdog_reset_out_oe
);

    // ************************************************************
    // Mode and state decode
    // ************************************************************
    wire logic        wide_mode  = (i_mode == epc_pkg::MODE_WIDE_A) || (i_mode == epc_pkg::MODE_WIDE_B);
    wire logic        mid_mode   = (i_mode == epc_pkg::MODE_MID_A) || (i_mode == epc_pkg::MODE_MID_B);
    wire logic        rom_mode   = (i_mode == epc_pkg::MODE_ROM);
    wire logic        lower_exp  = wide_mode | mid_mode;
    wire logic        exp_mode   = lower_exp | rom_mode;
    wire logic        hold_bit   = i_standby_output_hold;
    wire logic [3:0]  cs_hi_en   = {i_chip_select7_enable, i_chip_select6_enable,
                                    i_chip_select5_enable, i_chip_select4_enable};

    // [RULE10] Top address select
    // [RULE11] Bit 20 select
    wire logic [3:0]  addr_sel   = {{3{mid_mode | rom_mode}} & ~{i_addr_bit23_port_sel, i_addr_bit22_port_sel,
                                    i_addr_bit21_port_sel}, mid_mode | (rom_mode & ~i_addr_bit20_port_sel)};

    // [RULE7] Release refused single-chip
    wire logic        release_ok = i_bus_release_req & exp_mode;

    epc_pkg::epc_state_type st_reg;
    epc_pkg::epc_state_type st_next;
    assign st_next = i_hw_standby ? epc_pkg::PST_HW_STBY :
                     !i_res_n     ? epc_pkg::PST_RESET   :
                     i_sw_standby ? epc_pkg::PST_SW_STBY :
                     release_ok   ? epc_pkg::PST_RELEASE : epc_pkg::PST_EXEC;

    logic [1:0] res_cnt_reg;
    wire logic [1:0] res_cnt_next = (st_next != epc_pkg::PST_RESET) ? 2'h0 :
                                    (res_cnt_reg == epc_pkg::RES_CNT_MAX) ? res_cnt_reg : res_cnt_reg + 2'h1;
    // [RULE3] Delay reached
    wire logic addr_delay_done = (res_cnt_reg >= epc_pkg::ADDR_LOW_LAST);

    // ************************************************************
    // Next pin values
    // ************************************************************
    logic [19:0] addr_out_next;
    logic        addr_oe_next;
    logic [3:0]  up_out_next;
    logic [3:0]  up_oe_next;
    logic        data_oe_next;
    logic [3:0]  strobe_out_next;
    logic        strobe_oe_next;
    logic [3:0]  cs_out_next;
    logic [3:0]  cs_oe_next;
    logic [3:0]  cs_hi_out_next;
    logic [3:0]  cs_hi_oe_next;

    always_comb
    begin
        // Default is keep: outputs hold except the data bus, which defaults to floating; inputs stay floating
        addr_out_next   = o_addr_out;
        addr_oe_next    = o_addr_oe;
        up_out_next     = o_upper_addr_out;
        up_oe_next      = o_upper_addr_oe;
        data_oe_next    = 1'b0;
        strobe_out_next = o_strobe_out;
        strobe_oe_next  = o_strobe_oe;
        cs_out_next     = o_cs_out;
        cs_oe_next      = o_cs_oe;
        cs_hi_out_next  = o_cs_hi_out;
        cs_hi_oe_next   = o_cs_hi_oe;
        case (st_next)
            // [RULE14] Hardware standby float
            epc_pkg::PST_HW_STBY:
            begin
                addr_oe_next   = 1'b0;
                up_oe_next     = 4'h0;
                strobe_oe_next = 1'b0;
                cs_oe_next     = 4'h0;
                cs_hi_oe_next  = 4'h0;
            end
            epc_pkg::PST_RESET:
            begin
                // [RULE2] Strobes and CS0 high
                // [RULE5] Mode 5 strobes
                strobe_oe_next  = exp_mode;
                strobe_out_next = epc_pkg::STROBE_IDLE;
                cs_oe_next      = {3'h0, lower_exp};
                cs_out_next     = epc_pkg::CS_IDLE;
                // [RULE4] Immediate upper float
                cs_hi_oe_next   = 4'h0;
                up_oe_next      = {3'h0, mid_mode & (addr_delay_done | o_upper_addr_oe[0])};
                // [RULE3] Address low later
                if (lower_exp && addr_delay_done)
                begin
                    addr_oe_next   = 1'b1;
                    addr_out_next  = epc_pkg::ADDR_ZERO;
                    up_out_next[0] = 1'b0;
                end
                else if (!lower_exp)
                begin
                    addr_oe_next = 1'b0;
                end
            end
            // [RULE8] Hold keeps outputs
            epc_pkg::PST_SW_STBY:
            begin
                addr_oe_next    = o_addr_oe & exp_mode & hold_bit;
                up_oe_next      = o_upper_addr_oe & addr_sel & {4{hold_bit}};
                // [RULE9] Standby chip select
                strobe_oe_next  = exp_mode & hold_bit;
                strobe_out_next = epc_pkg::STROBE_IDLE;
                cs_oe_next      = i_cs_ddr & {4{exp_mode & hold_bit}};
                cs_out_next     = epc_pkg::CS_IDLE;
                // [RULE12] Upper chip select standby
                cs_hi_oe_next   = cs_hi_en & {4{exp_mode & hold_bit}};
                cs_hi_out_next  = epc_pkg::CS_IDLE;
            end
            // [RULE10] Release floats bus
            epc_pkg::PST_RELEASE:
            begin
                addr_oe_next   = 1'b0;
                up_oe_next     = 4'h0;
                strobe_oe_next = 1'b0;
                cs_oe_next     = 4'h0;
                cs_hi_oe_next  = 4'h0;
            end
            epc_pkg::PST_EXEC:
            begin
                addr_oe_next    = exp_mode;
                addr_out_next   = i_addr[19:0];
                // [RULE11] Address or port
                up_oe_next      = addr_sel;
                up_out_next     = i_addr[23:20];
                data_oe_next    = exp_mode & i_data_drive;
                strobe_oe_next  = exp_mode;
                strobe_out_next = i_strobe;
                cs_oe_next      = i_cs_ddr & {4{exp_mode}};
                cs_out_next     = i_cs[3:0];
                // [RULE12] Enable selects function
                cs_hi_oe_next   = cs_hi_en & {4{exp_mode}};
                cs_hi_out_next  = i_cs[7:4];
            end
            default:
            begin
                addr_oe_next = 1'b0;
            end
        endcase
    end

    // ************************************************************
    // Output registers
    // ************************************************************
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            st_reg                  <= epc_pkg::PST_RESET;
            res_cnt_reg             <= 2'h0;
            o_port_input_force      <= 1'b1;
            o_bus_released          <= 1'b0;
            o_addr_out              <= 20'h00000;
            o_addr_oe               <= 1'b0;
            o_upper_addr_out        <= 4'h0;
            o_upper_addr_oe         <= 4'h0;
            o_upper_port_mode       <= 4'hf;
            o_data_oe               <= 1'b0;
            o_strobe_out            <= 4'hf;
            o_strobe_oe             <= 1'b0;
            o_cs_out                <= 4'hf;
            o_cs_oe                 <= 4'h0;
            o_cs_hi_out             <= 4'hf;
            o_cs_hi_oe              <= 4'h0;
            o_clk_pin_oe            <= 1'b0;
            o_watchdog_reset_out    <= 1'b0;
            o_watchdog_reset_out_oe <= 1'b0;
        end
        else if (i_ce)
        begin
            st_reg                  <= st_next;
            res_cnt_reg             <= res_cnt_next;
            // [RULE1] Ports to input
            o_port_input_force      <= (st_next == epc_pkg::PST_RESET);
            o_bus_released          <= (st_next == epc_pkg::PST_RELEASE);
            o_addr_out              <= addr_out_next;
            o_addr_oe               <= addr_oe_next;
            o_upper_addr_out        <= up_out_next;
            o_upper_addr_oe         <= up_oe_next;
            o_upper_port_mode       <= ~addr_sel;
            o_data_oe               <= data_oe_next;
            o_strobe_out            <= strobe_out_next;
            o_strobe_oe             <= strobe_oe_next;
            o_cs_out                <= cs_out_next;
            o_cs_oe                 <= cs_oe_next;
            o_cs_hi_out             <= cs_hi_out_next;
            o_cs_hi_oe              <= cs_hi_oe_next;
            // [RULE6] Clock pin output
            o_clk_pin_oe            <= !i_hw_standby && (!i_res_n || !i_clock_out_stop);
            // [RULE13] Watchdog reset drive
            o_watchdog_reset_out_oe <= (st_next == epc_pkg::PST_RESET) && i_watchdog_overflow_reset;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    wire logic in_reset = i_ce && !i_hw_standby && !i_res_n;

    sequence res_low_three;
        (in_reset && lower_exp)[*3];
    endsequence

    sequence sw_hold_entry;
        i_ce && (st_next == epc_pkg::PST_SW_STBY) && (st_reg == epc_pkg::PST_SW_STBY) && hold_bit;
    endsequence

    a_ports_input_reset: assert property (in_reset |=> o_port_input_force) // [RULE1]
        else $error("ports not forced to input in reset");
    a_reset_strobes_high: assert property ((in_reset && wide_mode) |=>
        (o_strobe_oe && o_strobe_out == 4'hf && o_cs_oe[0] && o_cs_out[0] && !o_data_oe)) // [RULE2]
        else $error("strobes or chip select 0 not high in reset");
    a_addr_low_delay: assert property (res_low_three |=> (o_addr_oe && o_addr_out == 20'h00000)) // [RULE3]
        else $error("address bus not low after reset delay");
    a_addr_not_early: assert property ((in_reset && res_cnt_reg == 2'h0 && !o_addr_oe) ##1 in_reset |=> // [RULE3]
        !o_addr_oe)
        else $error("address bus driven before reset delay");
    a_mid_upper_float: assert property ((in_reset && mid_mode) |=>
        (o_upper_addr_oe[3:1] == 3'h0 && o_cs_oe[3:1] == 3'h0 && o_cs_hi_oe == 4'h0)) // [RULE4]
        else $error("upper pins not floated in reset");
    a_rom_reset_float: assert property ((in_reset && rom_mode) |=>
        (!o_addr_oe && !o_data_oe && o_strobe_oe && o_strobe_out == 4'hf)) // [RULE5]
        else $error("mode 5 reset pin state wrong");
    a_clock_pin_out: assert property (in_reset |=> o_clk_pin_oe) // [RULE6]
        else $error("clock pin not output after reset");
    a_release_refused: assert property ((i_ce && !exp_mode) |=> !o_bus_released) // [RULE7]
        else $error("bus released in single-chip mode");
    a_hold_keeps_addr: assert property (sw_hold_entry |=> $stable(o_addr_out) && $stable(o_upper_addr_out)) // [RULE8]
        else $error("held address changed in standby");
    a_cs_standby_hold: assert property ((i_ce && st_next == epc_pkg::PST_SW_STBY && exp_mode && i_cs_ddr[1]) |=>
        (o_cs_oe[1] == $past(hold_bit) && o_cs_out[1])) // [RULE9]
        else $error("chip select standby state wrong");
    a_upper_addr_exec: assert property ((i_ce && st_next == epc_pkg::PST_EXEC) |=>
        (o_upper_addr_oe == $past(addr_sel) && o_upper_port_mode == ~o_upper_addr_oe)) // [RULE10]
        else $error("top address select wrong");
    a_bit20_rom: assert property ((i_ce && st_next == epc_pkg::PST_EXEC && rom_mode) |=>
        (o_upper_addr_oe[0] == !$past(i_addr_bit20_port_sel))) // [RULE11]
        else $error("address bit 20 select wrong");
    a_cs_hi_release: assert property ((i_ce && st_next == epc_pkg::PST_RELEASE) |=>
        (o_cs_hi_oe == 4'h0 && o_cs_oe == 4'h0 && o_upper_addr_oe == 4'h0)) // [RULE12]
        else $error("chip selects driven in bus release");
    a_watchdog_reset_out: assert property (i_ce |=> // [RULE13]
        (o_watchdog_reset_out_oe == $past(in_reset && i_watchdog_overflow_reset) && !o_watchdog_reset_out))
        else $error("reset output drive wrong");
    a_hw_standby_float: assert property ((i_ce && i_hw_standby) |=> (!o_addr_oe && !o_data_oe && !o_strobe_oe
        && o_cs_oe == 4'h0 && o_cs_hi_oe == 4'h0 && o_upper_addr_oe == 4'h0 && !o_clk_pin_oe)) // [RULE14]
        else $error("pin driven in hardware standby");

endmodule // epc_pin_ctrl

`default_nettype wire

// >>> epc_pkg.sv
// Constants and state type for the external bus pin state controller
//
// Operation
// [RULE1] When the reset input goes low, every port pin returns to input direction in any mode.
// [RULE2] In modes 1 and 2 reset drives the address strobe, read strobe, both write strobes and chip select 0 high and floats the data bus.
// [RULE3] In modes 1 to 4 the address bus is driven low 2.5 clock cycles after the reset input is sampled low.
// [RULE4] In modes 3 and 4 upper address and chip-select pins in bus use float at once when reset goes low.
// [RULE5] In mode 5 reset drives all strobes high and floats both the address bus and the data bus.
// [RULE6] The shared clock output pin becomes an output on the first clock edge after reset goes low, in every mode.
// [RULE7] In single-chip modes any bus-release request is refused and all pins stay general I/O.
// [RULE8] A held pin in standby or bus release floats if it is an input and keeps its last level if it is an output.
// [RULE9] In expanded modes a chip select with its direction bit set goes high in software standby when the hold bit is 1, floats when it is 0, and floats in bus release.
// [RULE10] The three top address pins are addresses when their enable bits are 0 and I/O when 1; as addresses they float in bus release and float or hold in standby by the hold bit.
// [RULE11] In mode 5 address bit 20 is output when its enable bit is 0 and reverts to a port when it is 1.
// [RULE12] The four upper chip selects are chip selects only when their enable bits are 1; then they go high or float in standby and float in bus release.
// [RULE13] The reset output pin drives low only for a reset caused by watchdog overflow and floats otherwise.
// [RULE14] In hardware standby every listed bus and port pin floats whatever the mode or configuration; the code does not set o_port_input_force there.
`default_nettype none

package epc_pkg;

    // Operating modes
    localparam logic [2:0] MODE_WIDE_A   = 3'h1;
    localparam logic [2:0] MODE_WIDE_B   = 3'h2;
    localparam logic [2:0] MODE_MID_A    = 3'h3;
    localparam logic [2:0] MODE_MID_B    = 3'h4;
    localparam logic [2:0] MODE_ROM      = 3'h5;

    // Address low delay after reset sampled low, in tenths of a nanosecond
    localparam int         CLK_PERIOD_DNS  = 250;
    localparam int         ADDR_LOW_DNS    = 625;
    localparam int         ADDR_LOW_CYC    = (ADDR_LOW_DNS + CLK_PERIOD_DNS - 1) / CLK_PERIOD_DNS;
    localparam logic [1:0] ADDR_LOW_LAST   = 2'(ADDR_LOW_CYC - 1);
    localparam logic [1:0] RES_CNT_MAX     = 2'h3;

    // Reset and idle pin values
    localparam logic [3:0] STROBE_IDLE     = 4'hf;
    localparam logic [3:0] CS_IDLE         = 4'hf;
    localparam logic [19:0] ADDR_ZERO      = 20'h00000;

    typedef enum logic [2:0] {
        PST_EXEC,
        PST_RELEASE,
        PST_SW_STBY,
        PST_HW_STBY,
        PST_RESET
    } epc_state_type;

endpackage : epc_pkg

`default_nettype wire

// >>> epc_bus_model.sv
// Far-side model: external memory seeing the resolved bus and strobe wires
`default_nettype none

module epc_bus_model
(
    input  wire logic        i_core_clk,
    input  wire logic [19:0] i_addr_out,
    input  wire logic        i_addr_oe,
    input  wire logic [3:0]  i_strobe_out,
    input  wire logic        i_strobe_oe,
    input  wire logic        i_cs0_out,
    input  wire logic        i_cs0_oe,
    output logic      [19:0] o_addr_wire,
    output logic      [3:0]  o_strobe_wire,
    output logic             o_cs0_wire,
    output logic      [15:0] o_write_count
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [19:0] last_addr   = 20'h00000;
    logic [15:0] write_count = 16'h0000;

    assign o_write_count = write_count;

    // Strobes and chip select have pull-ups; a floating address shows the inverse of its last value
    assign o_strobe_wire = i_strobe_oe ? i_strobe_out : 4'hf;
    assign o_cs0_wire    = i_cs0_oe ? i_cs0_out : 1'h1;
    assign o_addr_wire   = i_addr_oe ? i_addr_out : ~last_addr;

    // Memory counts the write cycles it accepts while selected
    always @(posedge i_core_clk)
    begin
        if (i_addr_oe)
            last_addr <= i_addr_out;
        if (!o_cs0_wire && !o_strobe_wire[3] && (!o_strobe_wire[1] || !o_strobe_wire[0]))
            write_count <= write_count + 16'h0001;
    end
endmodule // epc_bus_model

`default_nettype wire

// >>> epc_pin_ctrl_bench.sv
// Self-checking bench for the external bus pin state controller
`default_nettype none
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin failures++; $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end

module epc_pin_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk, rst, ce, res_n, hws, sws, brq, hold, s23, s22, s21, s20, e7, e6, e5, e4, cstop, wdog, ddrive;
    logic [2:0]  mode;
    logic [3:0]  ddr, strobe;
    logic [7:0]  cs;
    logic [23:0] addr;
    logic        pif, rel, addr_oe, data_oe, strobe_oe, clk_oe, wd_out, wd_oe;
    logic [19:0] addr_out, addr_wire;
    logic [3:0]  up_out, up_oe, up_port, strobe_out, cs_out, cs_oe, cshi_out, cshi_oe, strobe_wire;
    logic        cs0_wire;
    logic [15:0] wr_count, wr_snap;
    int          failures = 0;
    int          checks = 0;
    int          cycles = 0;

    epc_pin_ctrl u_epc_pin_ctrl (.i_core_clk(clk), .i_rst(rst), .i_ce(ce), .i_res_n(res_n), .i_mode(mode),
        .i_hw_standby(hws), .i_sw_standby(sws), .i_bus_release_req(brq), .i_standby_output_hold(hold),
        .i_addr_bit23_port_sel(s23), .i_addr_bit22_port_sel(s22), .i_addr_bit21_port_sel(s21),
        .i_addr_bit20_port_sel(s20), .i_chip_select7_enable(e7), .i_chip_select6_enable(e6),
        .i_chip_select5_enable(e5), .i_chip_select4_enable(e4), .i_cs_ddr(ddr), .i_clock_out_stop(cstop),
        .i_watchdog_overflow_reset(wdog), .i_addr(addr), .i_strobe(strobe), .i_cs(cs), .i_data_drive(ddrive),
        .o_port_input_force(pif), .o_bus_released(rel), .o_addr_out(addr_out), .o_addr_oe(addr_oe),
        .o_upper_addr_out(up_out), .o_upper_addr_oe(up_oe), .o_upper_port_mode(up_port), .o_data_oe(data_oe),
        .o_strobe_out(strobe_out), .o_strobe_oe(strobe_oe), .o_cs_out(cs_out), .o_cs_oe(cs_oe),
        .o_cs_hi_out(cshi_out), .o_cs_hi_oe(cshi_oe), .o_clk_pin_oe(clk_oe),
        .o_watchdog_reset_out(wd_out), .o_watchdog_reset_out_oe(wd_oe));

    epc_bus_model u_epc_bus_model (.i_core_clk(clk), .i_addr_out(addr_out), .i_addr_oe(addr_oe),
        .i_strobe_out(strobe_out), .i_strobe_oe(strobe_oe), .i_cs0_out(cs_out[0]), .i_cs0_oe(cs_oe[0]),
        .o_addr_wire(addr_wire), .o_strobe_wire(strobe_wire), .o_cs0_wire(cs0_wire), .o_write_count(wr_count));

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic end_sim();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Waits n edges, then lands just after the last one
    task automatic go(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            failures++;
            end_sim();
        end
    end

    initial
    begin
        {rst, ce, res_n, hold, ddrive} = 5'h1f;
        {hws, sws, brq, s23, s22, s21, s20, cstop, wdog} = 9'h000;
        {e7, e6, e5, e4} = 4'hf;
        mode = 3'h1; ddr = 4'hf; strobe = 4'h0; cs = 8'h00; addr = 24'h5a5a5a;
        repeat (20) @(posedge clk);
        #2 rst = 1'b0;
        go(3);
        // Mode 1 reset during an access
        res_n = 1'b0;
        go(1);
        `CHK("port_input_force", 1'h1, pif)
        `CHK("strobes", 5'h1f, {strobe_oe, strobe_out})
        `CHK("strobe_wire", 4'hf, strobe_wire)
        `CHK("cs0", 2'h3, {cs_oe[0], cs_out[0]})
        `CHK("data_oe", 1'h0, data_oe)
        `CHK("clk_pin_oe", 1'h1, clk_oe)
        `CHK("cs0_wire", 1'h1, cs0_wire)
        `CHK("writes_before", 1'h1, wr_count != 16'h0000)
        wr_snap = wr_count;
        go(2);
        `CHK("addr_low", 21'h100000, {addr_oe, addr_out})
        `CHK("no_writes", wr_snap, wr_count)
        // Mode 3 execution then reset
        res_n = 1'b1; mode = 3'h3;
        go(2);
        `CHK("upper_addr_oe", 4'hf, up_oe)
        res_n = 1'b0;
        go(1);
        `CHK("upper_float", 11'h000, {up_oe[3:1], cs_oe[3:1], cshi_oe})
        go(2);
        `CHK("a20_low", 2'h2, {up_oe[0], up_out[0]})
        // Mode 5: A20 select, then reset
        res_n = 1'b1; mode = 3'h5;
        go(2);
        `CHK("a20_addr", 2'h1, {up_port[0], up_oe[0]})
        s20 = 1'b1;
        go(2);
        `CHK("a20_port", 2'h2, {up_port[0], up_oe[0]})
        res_n = 1'b0; s20 = 1'b0;
        go(1);
        `CHK("rom_reset", 7'h1f, {addr_oe, data_oe, strobe_oe, strobe_out})
        `CHK("rom_addr_wire", 20'h5a5a5, addr_wire)
        // Bus release refused then granted
        res_n = 1'b1; mode = 3'h6; brq = 1'b1;
        go(2);
        `CHK("release_single", 5'h0f, {rel, up_port})
        mode = 3'h3; s23 = 1'b1;
        go(2);
        `CHK("release_on", 1'h1, rel)
        `CHK("release_cs", 8'h00, {cs_oe, cshi_oe})
        `CHK("release_upper", 4'h8, {up_port[3], up_oe[2:0]})
        // Software standby with hold set, then cleared
        brq = 1'b0; s23 = 1'b0;
        go(2);
        sws = 1'b1; addr = 24'h123456; ddr = 4'hb;
        go(2);
        `CHK("held_addr", 21'h1a5a5a, {addr_oe, addr_out})
        `CHK("stby_strobe", 5'h1f, {strobe_oe, strobe_out})
        `CHK("stby_cs", 16'hbfff, {cs_oe, cs_out, cshi_oe, cshi_out})
        hold = 1'b0;
        go(2);
        `CHK("stby_float", 10'h000, {addr_oe, up_oe, cs_oe, strobe_oe})
        `CHK("stby_cshi", 4'h0, cshi_oe)
        sws = 1'b0; hold = 1'b1;
        // Watchdog-caused reset drives the reset output
        wdog = 1'b1; cstop = 1'b1; res_n = 1'b0;
        go(1);
        `CHK("wd_out", 3'h5, {clk_oe, wd_out, wd_oe})
        wdog = 1'b0;
        go(1);
        `CHK("wd_float", 1'h0, wd_oe)
        // Hardware standby floats everything
        res_n = 1'b1; mode = 3'h1; hws = 1'b1;
        go(2);
        `CHK("hw_stby", 16'h0000, {addr_oe, data_oe, strobe_oe, clk_oe, cs_oe, cshi_oe, up_oe})
        // Clock enable low freezes the floated pins
        ce = 1'b0; hws = 1'b0;
        go(2);
        `CHK("ce_freeze", 16'h0000, {addr_oe, data_oe, strobe_oe, clk_oe, cs_oe, cshi_oe, up_oe})
        end_sim();
    end
endmodule // epc_pin_ctrl_bench

`undef CHK
`default_nettype wire
